/* bbd_pkg.sv */
// constants shared by the battery backup domain controller
package bbd_pkg;

	// ************************************************
	// register indices (byte address = 4 * index)
	// ************************************************
	localparam logic [1:0] IDX_CONTROL = 2'h0;
	localparam logic [1:0] IDX_STATUS = 2'h1;
	localparam logic [1:0] IDX_RET0 = 2'h2;
	localparam logic [1:0] IDX_RET1 = 2'h3;

	// ************************************************
	// backup_control fields
	// ************************************************
	localparam int CTL_HIGH_DRIVE = 5;
	localparam int CTL_OUT_SEL = 4;
	localparam int CTL_OSC_ON = 3;
	localparam int CTL_FAIL_MON = 2;
	localparam int CTL_UNLOCK = 1;
	localparam int CTL_DOM_RESET = 0;
	localparam logic [7:0] CONTROL_RESET = 8'h00;

	// ************************************************
	// backup_status fields
	// ************************************************
	localparam int STS_ABSENT = 7;
	localparam int STS_STABLE = 3;
	localparam int STS_OSC_FAIL = 2;
	localparam int STS_BROWNOUT = 1;
	localparam int STS_INSERT = 0;

	// ************************************************
	// timing
	// ************************************************
	localparam longint CLK_HZ = 25000000;
	localparam longint XTAL_HZ = 32768;
	localparam longint FAIL_SWINGS = 64;
	// quiet time covering one expected swing plus 64 lost ones, rounded up
	localparam longint FAIL_CYC_CALC =
		((FAIL_SWINGS + 1) * CLK_HZ + XTAL_HZ - 1) / XTAL_HZ;
	localparam int FAIL_CYCLES = int'(FAIL_CYC_CALC);
	localparam int STABLE_SWINGS = 1024;
	localparam int SWITCH_CYCLES = 4;
	// crystal edges per half period of each tick rate
	localparam logic [14:0] HALF_FAST = 15'h0010;
	localparam logic [14:0] HALF_SLOW = 15'h4000;

endpackage : bbd_pkg

/* bbd_ctrl.sv */
// battery backup domain controller with avalon-mm register slave
`timescale 1ns/1ps
`default_nettype none

module bbd_ctrl #(
	parameter int ADDR_W = 4,
	parameter int STABLE_SWINGS = bbd_pkg::STABLE_SWINGS,
	parameter int FAIL_CYCLES = bbd_pkg::FAIL_CYCLES,
	parameter int SWITCH_CYCLES = bbd_pkg::SWITCH_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic ccp_window,
	input wire logic main_bod_low,
	input wire logic vbat_present,
	input wire logic vbat_inserted,
	input wire logic vbat_lost,
	input wire logic battery_drop_trip,
	input wire logic xtal_swing,
	output logic power_from_battery,
	output logic battery_drop_monitor,
	output logic main_side_reset,
	output logic crystal_drive_on,
	output logic high_drive_mode,
	output logic counter_tick
);

	// ************************************************
	// elaboration checks
	// ************************************************
	if (ADDR_W < 4) begin : g_chk_addr
		$error("ADDR_W must be at least 4");
	end
	if (STABLE_SWINGS < 1 || STABLE_SWINGS > 2047) begin : g_chk_stab
		$error("STABLE_SWINGS out of range");
	end
	if (FAIL_CYCLES < 2 || FAIL_CYCLES > 65535) begin : g_chk_fail
		$error("FAIL_CYCLES out of range");
	end
	if (SWITCH_CYCLES < 1 || SWITCH_CYCLES > 15) begin : g_chk_sw
		$error("SWITCH_CYCLES out of range");
	end

	// ************************************************
	// types
	// ************************************************
	typedef enum logic [3:0] {
		PW_MAIN = 4'h1,
		PW_TO_BATT = 4'h2,
		PW_BATT = 4'h4,
		PW_TO_MAIN = 4'h8
	} bbd_pw_e;

	typedef struct packed {
		bbd_pw_e pw;
		logic [3:0] sw_cnt;
		logic out_batt;
		logic out_mrst;
		logic bod_s1;
		logic bod_s2;
		logic pres_s1;
		logic pres_s2;
		logic ins_s1;
		logic ins_s2;
		logic lost_s1;
		logic lost_s2;
		logic drop_s1;
		logic drop_s2;
		logic xo_s1;
		logic xo_s2;
		logic xo_s3;
		logic start;
		logic wait_st;
		logic [7:0] rdata;
		logic drst;
		logic hdm;
		logic sel;
		logic osc_on;
		logic fmon;
		logic unlock;
		logic stable;
		logic ofail;
		logic absent;
		logic bbo;
		logic insert;
		logic [7:0] ret0;
		logic [7:0] ret1;
		logic [10:0] stab_cnt;
		logic [15:0] fail_cnt;
		logic [13:0] pre_cnt;
		logic tick;
	} bbd_state_s;

	localparam logic [3:0] SW_LAST = 4'(SWITCH_CYCLES - 1);
	localparam logic [10:0] STAB_LAST = 11'(STABLE_SWINGS - 1);
	localparam logic [15:0] FAIL_LAST = 16'(FAIL_CYCLES - 1);

	// register index of a byte address, valid when word aligned and below 16
	function automatic logic [2:0] bbd_decode(
		input logic [ADDR_W-1:0] a
	);
		logic hit;
		hit = (a[1:0] == 2'h0);
		if (ADDR_W > 4) begin
			hit = hit && ((a >> 4) == '0);
		end
		return {hit, a[3:2]};
	endfunction

	bbd_state_s r;
	bbd_state_s n;

	logic on_main;
	logic switching;
	logic xo_edge;
	logic req;
	logic done;
	logic [2:0] dec;
	logic wr;
	logic [7:0] wd;
	logic [7:0] rv;
	logic [14:0] half;
	logic dom_clear;

	// ************************************************
	// next state
	// ************************************************
	always_comb begin
		n = r;
		// pin synchronisers, first stage read only by second
		n.bod_s1 = main_bod_low;
		n.bod_s2 = r.bod_s1;
		n.pres_s1 = vbat_present;
		n.pres_s2 = r.pres_s1;
		n.ins_s1 = vbat_inserted;
		n.ins_s2 = r.ins_s1;
		n.lost_s1 = vbat_lost;
		n.lost_s2 = r.lost_s1;
		n.drop_s1 = battery_drop_trip;
		n.drop_s2 = r.drop_s1;
		n.xo_s1 = xtal_swing;
		n.xo_s2 = r.xo_s1;
		n.xo_s3 = r.xo_s2;

		on_main = (r.pw == PW_MAIN);
		switching = (r.pw == PW_TO_BATT) || (r.pw == PW_TO_MAIN);
		xo_edge = r.xo_s2 && !r.xo_s3 && r.osc_on;

		// power switch sequencing
		unique case (r.pw)
			PW_MAIN: begin
				if (r.bod_s2 && !r.insert) begin
					n.pw = PW_TO_BATT;
					n.sw_cnt = 4'h0;
				end
			end
			PW_TO_BATT: begin
				if (r.sw_cnt == SW_LAST) begin
					n.pw = PW_BATT;
				end else begin
					n.sw_cnt = r.sw_cnt + 4'h1;
				end
			end
			PW_BATT: begin
				if (!r.bod_s2) begin
					n.pw = PW_TO_MAIN;
					n.sw_cnt = 4'h0;
				end
			end
			PW_TO_MAIN: begin
				if (r.sw_cnt == SW_LAST) begin
					n.pw = PW_MAIN;
				end else begin
					n.sw_cnt = r.sw_cnt + 4'h1;
				end
			end
			default: begin
				n.pw = PW_MAIN;
				n.sw_cnt = 4'h0;
			end
		endcase

		// bus handshake: one wait cycle, then the answer
		req = avs_read || avs_write;
		done = req && !r.wait_st;
		dec = bbd_decode(avs_address);
		wd = avs_writedata[7:0];
		n.wait_st = 1'b1;

		// read value, off-main gives zero, locked gives zero except the status supervision flags
		rv = 8'h00;
		if (on_main && dec[2]) begin
			unique case (dec[1:0])
				bbd_pkg::IDX_CONTROL: begin
					if (r.unlock) begin
						rv[bbd_pkg::CTL_HIGH_DRIVE] = r.hdm;
						rv[bbd_pkg::CTL_OUT_SEL] = r.sel;
						rv[bbd_pkg::CTL_OSC_ON] = r.osc_on;
						rv[bbd_pkg::CTL_FAIL_MON] = r.fmon;
						rv[bbd_pkg::CTL_UNLOCK] = r.unlock;
					end
				end
				bbd_pkg::IDX_STATUS: begin
					// supervision flags always visible
					rv[bbd_pkg::STS_ABSENT] = r.absent;
					rv[bbd_pkg::STS_BROWNOUT] = r.bbo;
					rv[bbd_pkg::STS_INSERT] = r.insert;
					if (r.unlock) begin
						rv[bbd_pkg::STS_STABLE] = r.stable;
						rv[bbd_pkg::STS_OSC_FAIL] = r.ofail;
					end
				end
				bbd_pkg::IDX_RET0: begin
					rv = r.unlock ? r.ret0 : 8'h00;
				end
				bbd_pkg::IDX_RET1: begin
					rv = r.unlock ? r.ret1 : 8'h00;
				end
			endcase
		end
		if (req && r.wait_st) begin
			n.wait_st = 1'b0;
			n.rdata = avs_read ? rv : 8'h00;
		end

		// writes land at the completing edge, only on main power
		wr = done && avs_write && avs_byteenable[0] && dec[2] && on_main;
		n.drst = 1'b0;
		if (wr && dec[1:0] == bbd_pkg::IDX_CONTROL) begin
			n.unlock = r.unlock || wd[bbd_pkg::CTL_UNLOCK];
			if (r.unlock) begin
				n.hdm = wd[bbd_pkg::CTL_HIGH_DRIVE];
				if (!r.osc_on) begin
					n.sel = wd[bbd_pkg::CTL_OUT_SEL];
				end
				n.osc_on = r.osc_on || wd[bbd_pkg::CTL_OSC_ON];
				n.fmon = r.fmon || wd[bbd_pkg::CTL_FAIL_MON];
				// one-cycle domain reset, blocked by enables in same write
				n.drst = wd[bbd_pkg::CTL_DOM_RESET] && ccp_window
					&& !wd[bbd_pkg::CTL_OSC_ON] && !wd[bbd_pkg::CTL_FAIL_MON];
			end
		end
		if (wr && dec[1:0] == bbd_pkg::IDX_STATUS) begin
			// write one to clear, sets below win
			if (wd[bbd_pkg::STS_ABSENT]) begin
				n.absent = 1'b0;
			end
			if (wd[bbd_pkg::STS_BROWNOUT]) begin
				n.bbo = 1'b0;
			end
			if (wd[bbd_pkg::STS_INSERT]) begin
				n.insert = 1'b0;
			end
			if (wd[bbd_pkg::STS_OSC_FAIL] && r.unlock) begin
				n.ofail = 1'b0;
			end
		end
		if (wr && r.unlock && dec[1:0] == bbd_pkg::IDX_RET0) begin
			n.ret0 = wd;
		end
		if (wr && r.unlock && dec[1:0] == bbd_pkg::IDX_RET1) begin
			n.ret1 = wd;
		end

		// oscillator start-up: stable after enough swings
		if (r.osc_on && !r.stable && xo_edge) begin
			if (r.stab_cnt == STAB_LAST) begin
				n.stable = 1'b1;
			end else begin
				n.stab_cnt = r.stab_cnt + 11'h001;
			end
		end

		// fail monitor: quiet time since the last swing
		if (r.fmon && r.osc_on && r.stable) begin
			if (xo_edge) begin
				n.fail_cnt = 16'h0000;
			end else if (r.fail_cnt == FAIL_LAST) begin
				n.ofail = 1'b1;
			end else begin
				n.fail_cnt = r.fail_cnt + 16'h0001;
			end
		end

		// prescaler, frozen while the supply switches
		half = r.sel ? bbd_pkg::HALF_FAST : bbd_pkg::HALF_SLOW;
		if (xo_edge && !switching) begin
			if ({1'b0, r.pre_cnt} == half - 15'h0001) begin
				n.pre_cnt = 14'h0000;
				n.tick = !r.tick;
			end else begin
				n.pre_cnt = r.pre_cnt + 14'h0001;
			end
		end

		// battery monitor trips only while on battery
		if (r.pw == PW_BATT && r.drop_s2) begin
			n.bbo = 1'b1;
		end

		// startup capture of the supervisor, first cycle after reset
		n.start = 1'b0;
		if (r.start) begin
			n.absent = !r.pres_s2 || r.absent;
			n.insert = r.ins_s2 || r.insert;
		end

		// domain reset: a pulse, or main reset after the domain lost power
		dom_clear = r.drst || (rst && r.lost_s2);
		if (dom_clear) begin
			n.hdm = 1'b0;
			n.sel = 1'b0;
			n.osc_on = 1'b0;
			n.fmon = 1'b0;
			n.stable = 1'b0;
			n.ofail = 1'b0;
			n.stab_cnt = 11'h000;
			n.fail_cnt = 16'h0000;
			n.pre_cnt = 14'h0000;
			n.tick = 1'b0;
		end
		if (rst && r.lost_s2) begin
			n.absent = 1'b0;
			n.bbo = 1'b0;
			n.insert = 1'b0;
			n.ret0 = 8'h00;
			n.ret1 = 8'h00;
		end

		// main reset leaves the battery domain running
		if (rst) begin
			n.unlock = 1'b0;
			n.wait_st = 1'b1;
			n.rdata = 8'h00;
			n.drst = 1'b0;
			n.start = 1'b1;
			if (!r.bod_s2) begin
				n.pw = PW_MAIN;
				n.sw_cnt = 4'h0;
			end
		end

		// registered outputs of the switch
		n.out_batt = (n.pw != PW_MAIN);
		n.out_mrst = (n.pw != PW_MAIN);
	end

	// ************************************************
	// state register
	// ************************************************
	always_ff @(posedge clk) begin
		r <= n;
	end

	// outputs straight from the state register
	assign avs_readdata = {24'h000000, r.rdata};
	assign avs_waitrequest = r.wait_st;
	assign power_from_battery = r.out_batt;
	assign battery_drop_monitor = r.out_batt;
	assign main_side_reset = r.out_mrst;
	assign crystal_drive_on = r.osc_on;
	assign high_drive_mode = r.hdm;
	assign counter_tick = r.tick;

endmodule // bbd_ctrl

`default_nettype wire

/* bbd_ctrl_asserts.sv */
// concurrent checks on the ports of the backup domain controller
`timescale 1ns/1ps
`default_nettype none
module bbd_ctrl_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic ccp_window,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic power_from_battery,
	input wire logic battery_drop_monitor,
	input wire logic main_side_reset,
	input wire logic crystal_drive_on,
	input wire logic high_drive_mode,
	input wire logic counter_tick
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// read taken and answered while main power is away
	sequence s_off_read;
		avs_read && avs_waitrequest && main_side_reset ##1 main_side_reset;
	endsequence
	// tick level held over two samples
	sequence s_frozen;
		$stable(counter_tick)[*2];
	endsequence
	property p_off_read;
		s_off_read |-> avs_readdata == 32'h0;
	endproperty
	property p_tick_hold;
		$rose(power_from_battery) |=> s_frozen;
	endproperty
	property p_monitor;
		battery_drop_monitor == power_from_battery;
	endproperty
	property p_main_reset;
		power_from_battery |-> main_side_reset;
	endproperty
	property p_osc_hold;
		$fell(crystal_drive_on) |-> $past(avs_write && !avs_waitrequest, 2);
	endproperty
	property p_ccp;
		$fell(crystal_drive_on) |-> $past(ccp_window, 2);
	endproperty
	property p_hd_cause;
		$changed(high_drive_mode) |-> $past(avs_write && !avs_waitrequest)
			|| $past(avs_write && !avs_waitrequest, 2);
	endproperty
	property p_hi_zero;
		!avs_waitrequest |-> avs_readdata[31:8] == 24'h0;
	endproperty
	a_off_read: assert property (p_off_read) else $error("read gave data off main power");
	a_tick_hold: assert property (p_tick_hold) else $error("tick moved during switch");
	a_monitor: assert property (p_monitor) else $error("battery monitor not with switch");
	a_main_reset: assert property (p_main_reset) else $error("main side not in reset");
	a_osc_hold: assert property (p_osc_hold) else $error("oscillator enable dropped");
	a_ccp: assert property (p_ccp) else $error("domain reset outside window");
	a_hd_cause: assert property (p_hd_cause) else $error("high drive changed alone");
	a_hi_zero: assert property (p_hi_zero) else $error("upper read bits not zero");
endmodule // bbd_ctrl_chk
bind bbd_ctrl bbd_ctrl_chk u_chk (.clk, .rst, .avs_read, .avs_write, .ccp_window,
	.avs_readdata, .avs_waitrequest, .power_from_battery, .battery_drop_monitor,
	.main_side_reset, .crystal_drive_on, .high_drive_mode, .counter_tick);
`default_nettype wire

/* bbd_ctrl_tb.sv */
// self-checking bench for the backup domain controller
`timescale 1ns/1ps
`default_nettype none
module bbd_ctrl_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic ccp_window = 1'b0;
	logic main_bod_low = 1'b0;
	logic vbat_present = 1'b0;
	logic vbat_inserted = 1'b1;
	logic vbat_lost = 1'b1;
	logic battery_drop_trip = 1'b0;
	logic xt_run = 1'b0;
	logic [1:0] xt_cnt = 2'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, power_from_battery, battery_drop_monitor, main_side_reset;
	logic crystal_drive_on, high_drive_mode, counter_tick;
	logic [7:0] q;
	int num_errors = 0;
	int samples_checked = 0;
	// ************************************************
	// clock, crystal and device
	// ************************************************
	always #20 clk = ~clk;
	// crystal swing of four clock periods while running
	always @(posedge clk) if (xt_run) xt_cnt <= xt_cnt + 2'h1;
	bbd_ctrl #(.STABLE_SWINGS(4), .FAIL_CYCLES(20), .SWITCH_CYCLES(4)) DUT (.clk, .rst,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'h1),
		.avs_readdata, .avs_waitrequest, .ccp_window, .main_bod_low, .vbat_present,
		.vbat_inserted, .vbat_lost, .battery_drop_trip, .xtal_swing(xt_cnt[1]),
		.power_from_battery, .battery_drop_monitor, .main_side_reset, .crystal_drive_on,
		.high_drive_mode, .counter_tick);
	// ************************************************
	// shared tasks
	// ************************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
			num_errors++;
		end
	endtask
	task automatic bus(input logic wr, input logic [1:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs_write <= wr;
		avs_read <= !wr;
		avs_address <= {idx, 2'h0};
		avs_writedata <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		chk({7'h0, avs_waitrequest}, 8'h00);
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic rd_chk(input logic [1:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		chk(q, exp);
	endtask
	task automatic wt_pwr(input logic v);
		int n;
		n = 0;
		while (power_from_battery !== v && n < 40) begin
			@(posedge clk);
			n++;
		end
		chk({7'h0, power_from_battery}, {7'h0, v});
	endtask
	// ************************************************
	// scenarios
	// ************************************************
	task automatic t_locked;
		main_bod_low <= 1'b1;
		repeat (20) @(posedge clk);
		chk({7'h0, power_from_battery}, 8'h00);
		main_bod_low <= 1'b0;
		rd_chk(2'h1, 8'h81);
		bus(1'b1, 2'h2, 8'h77);
		bus(1'b1, 2'h1, 8'h81);
		rd_chk(2'h1, 8'h00);
		bus(1'b1, 2'h0, 8'h02);
		rd_chk(2'h0, 8'h02);
		rd_chk(2'h2, 8'h00);
	endtask
	task automatic t_regs;
		bus(1'b1, 2'h2, 8'ha5);
		bus(1'b1, 2'h3, 8'h5a);
		rd_chk(2'h2, 8'ha5);
		rd_chk(2'h3, 8'h5a);
		bus(1'b1, 2'h0, 8'h32);
		rd_chk(2'h0, 8'h32);
		bus(1'b1, 2'h0, 8'h00);
		rd_chk(2'h0, 8'h02);
		bus(1'b1, 2'h0, 8'h3a);
		rd_chk(2'h0, 8'h3a);
		chk({7'h0, high_drive_mode}, 8'h01);
		chk({7'h0, crystal_drive_on}, 8'h01);
		bus(1'b1, 2'h0, 8'h22);
		rd_chk(2'h0, 8'h3a);
	endtask
	task automatic t_osc;
		int n;
		logic t;
		xt_run <= 1'b1;
		repeat (60) @(posedge clk);
		rd_chk(2'h1, 8'h08);
		for (int k = 0; k < 2; k++) begin
			t = counter_tick;
			n = 0;
			while (counter_tick === t && n < 200) begin
				@(posedge clk);
				n++;
			end
		end
		chk(n[7:0], 8'h40);
		bus(1'b1, 2'h0, 8'h3e);
		xt_run <= 1'b0;
		repeat (10) @(posedge clk);
		rd_chk(2'h1, 8'h08);
		repeat (30) @(posedge clk);
		rd_chk(2'h1, 8'h0c);
		xt_run <= 1'b1;
		repeat (8) @(posedge clk);
		bus(1'b1, 2'h1, 8'h04);
		rd_chk(2'h1, 8'h08);
	endtask
	task automatic t_power;
		main_bod_low <= 1'b1;
		wt_pwr(1'b1);
		chk({6'h0, battery_drop_monitor, main_side_reset}, 8'h03);
		bus(1'b1, 2'h2, 8'hff);
		rd_chk(2'h2, 8'h00);
		battery_drop_trip <= 1'b1;
		repeat (10) @(posedge clk);
		battery_drop_trip <= 1'b0;
		main_bod_low <= 1'b0;
		wt_pwr(1'b0);
		bus(1'b1, 2'h0, 8'h22);
		rd_chk(2'h2, 8'ha5);
		rd_chk(2'h1, 8'h0a);
	endtask
	task automatic t_dreset;
		ccp_window <= 1'b1;
		bus(1'b1, 2'h0, 8'h2f);
		rd_chk(2'h0, 8'h3e);
		chk({7'h0, crystal_drive_on}, 8'h01);
		ccp_window <= 1'b0;
		bus(1'b1, 2'h0, 8'h23);
		rd_chk(2'h0, 8'h3e);
		ccp_window <= 1'b1;
		bus(1'b1, 2'h0, 8'h23);
		repeat (3) @(posedge clk);
		rd_chk(2'h0, 8'h02);
		chk({7'h0, crystal_drive_on}, 8'h00);
		chk({7'h0, high_drive_mode}, 8'h00);
		rd_chk(2'h1, 8'h02);
		ccp_window <= 1'b0;
	endtask
	task automatic tally_and_finish;
		if (num_errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ************************************************
	// main sequence and watchdog
	// ************************************************
	// reset with domain supply lost, then the scenarios
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		vbat_lost <= 1'b0;
		t_locked;
		t_regs;
		t_osc;
		t_power;
		t_dreset;
		tally_and_finish;
	end
	// cut a hang short
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		tally_and_finish;
	end
endmodule // bbd_ctrl_tb
`default_nettype wire
